// >>> include/awht_defs.vh
// constants of the window comparator threshold block
// assumes inclusion by bare name from design files
`ifndef AWHT_DEFS_VH
`define AWHT_DEFS_VH

// register byte offsets
`define AWHT_OFF_CTRL 8'h00
`define AWHT_OFF_STATUS 8'h04
`define AWHT_OFF_MASK 8'h08
`define AWHT_OFF_STAGE 8'h0c
`define AWHT_OFF_RESULT 8'h10
`define AWHT_OFF_UPPER 8'h14
`define AWHT_OFF_LOWER 8'h18

// control fields
`define AWHT_CTRL_EN_BIT 0
`define AWHT_CTRL_MODE_LSB 4
`define AWHT_CTRL_MODE_MSB 6
`define AWHT_CTRL_ACC_LSB 8
`define AWHT_CTRL_ACC_MSB 10

// status and mask fields
`define AWHT_ST_READY_BIT 0
`define AWHT_ST_MATCH_BIT 1

// reset values
`define AWHT_RST_UPPER 16'h0000
`define AWHT_RST_LOWER 16'h0000
`define AWHT_RST_STAGE 8'h00
`define AWHT_RST_RESULT 16'h0000
`define AWHT_RST_MODE 3'h0
`define AWHT_RST_ACC 3'h0
`define AWHT_RST_FLAGS 2'h0

// window compare modes
`define AWHT_MODE_NONE 3'h0
`define AWHT_MODE_BELOW 3'h1
`define AWHT_MODE_ABOVE 3'h2
`define AWHT_MODE_INSIDE 3'h3
`define AWHT_MODE_OUTSIDE 3'h4

// largest accumulation shift, 64 samples
`define AWHT_ACC_MAX 3'h6

// bus responses
`define AWHT_RESP_OKAY 2'h0
`define AWHT_RESP_SLVERR 2'h2

`endif

// >>> verilog/awht_cmp.v
// accumulator and window comparator
// assumes samples synchronous to mclk, one per valid pulse
`timescale 1ns/1ns
`include "awht_defs.vh"

module awht_cmp #(
    parameter RAW_W = 10,
    parameter SUM_W = 16
) (
    input wire mclk,
    input wire rst,
    input wire sample_valid,
    input wire [RAW_W-1:0] sample,
    input wire [2:0] accum_shift,
    input wire [2:0] mode,
    input wire [SUM_W-1:0] upper,
    input wire [SUM_W-1:0] lower,
    output reg done,
    output reg [SUM_W-1:0] total,
    output reg match
);

    reg [SUM_W-1:0] sum;
    reg [6:0] count;
    wire [2:0] shift_lim;
    wire [6:0] last_count;
    wire [SUM_W-1:0] next_sum;

    // unsigned magnitude test against the window
    function window_hit;
        input [2:0] sel;
        input [SUM_W-1:0] value;
        input [SUM_W-1:0] hi;
        input [SUM_W-1:0] lo;
        begin
            case (sel)
                `AWHT_MODE_BELOW: window_hit = value < lo;
                `AWHT_MODE_ABOVE: window_hit = value > hi;
                `AWHT_MODE_INSIDE: window_hit = (value >= lo) && (value <= hi);
                `AWHT_MODE_OUTSIDE: window_hit = (value < lo) || (value > hi);
                default: window_hit = 1'b0;
            endcase
        end
    endfunction

    assign shift_lim = (accum_shift > `AWHT_ACC_MAX) ? `AWHT_ACC_MAX : accum_shift;
    assign last_count = (7'h01 << shift_lim) - 7'h01;
    // raw sample zero extended into the low bits
    assign next_sum = sum + {{(SUM_W-RAW_W){1'b0}}, sample};

    always @(posedge mclk) begin
        if (rst) begin
            sum <= {SUM_W{1'b0}};
            count <= 7'h00;
            done <= 1'b0;
            total <= {SUM_W{1'b0}};
            match <= 1'b0;
        end else begin
            done <= 1'b0;
            if (sample_valid) begin
                if (count == last_count) begin
                    // compare the finished total, not each sample
                    sum <= {SUM_W{1'b0}};
                    count <= 7'h00;
                    done <= 1'b1;
                    total <= next_sum;
                    match <= window_hit(mode, next_sum, upper, lower);
                end else begin
                    sum <= next_sum;
                    count <= count + 7'h01;
                end
            end
        end
    end

endmodule

// >>> verilog/awht_top.v
// window threshold block with axi4-lite register slave
// assumes one clock, synchronous active-high reset, synchronous samples
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "awht_defs.vh"

module awht_top #(
    parameter ADDR_W = 8,
    parameter RAW_W = 10,
    parameter SUM_W = 16
) (
    input wire mclk,
    input wire rst,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire sample_valid,
    input wire [RAW_W-1:0] sample,
    output wire window_match_flag,
    output wire irq
);

    // software state
    reg ctrl_enable;
    reg [2:0] window_compare_mode_select;
    reg [2:0] accum_shift;
    reg [SUM_W-1:0] window_upper_limit;
    reg [SUM_W-1:0] window_lower_limit;
    reg [7:0] stage_byte;
    reg [SUM_W-1:0] conversion_value;
    reg [1:0] status;
    reg [1:0] mask;

    // bus holding state
    reg aw_held;
    reg [ADDR_W-1:0] aw_addr;
    reg w_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    wire cmp_done;
    wire [SUM_W-1:0] cmp_total;
    wire cmp_match;

    wire wr_fire;
    wire rd_take;
    wire [7:0] wr_off;
    wire [7:0] rd_off;
    wire [7:0] upper_high_byte;
    wire [7:0] lower_high_byte;
    wire [7:0] result_high_byte;

    reg [31:0] rd_mux;
    reg rd_ok;
    reg wr_ok;
    reg rd_clr_status;
    reg rd_clr_result;
    reg [1:0] wr_clr;
    reg [1:0] flag_set;
    reg [1:0] next_status;

    // merge one write into a 16-bit pair through the staging byte
    function [15:0] pair_write;
        input [15:0] old;
        input [7:0] staged;
        input [15:0] data;
        input [1:0] strb;
        begin
            if (strb == 2'h3) begin
                pair_write = data;
            end else if (strb == 2'h2) begin
                pair_write = {data[15:8], staged};
            end else begin
                pair_write = old;
            end
        end
    endfunction

    // word-aligned byte offset of an address
    function [7:0] word_off;
        input [ADDR_W-1:0] addr;
        reg [7:0] wide;
        begin
            wide = addr[7:0];
            word_off = {wide[7:2], 2'h0};
        end
    endfunction

    awht_cmp #(
        .RAW_W(RAW_W),
        .SUM_W(SUM_W)
    ) u_cmp (
        .mclk(mclk),
        .rst(rst),
        .sample_valid(sample_valid & ctrl_enable),
        .sample(sample),
        .accum_shift(accum_shift),
        .mode(window_compare_mode_select),
        .upper(window_upper_limit),
        .lower(window_lower_limit),
        .done(cmp_done),
        .total(cmp_total),
        .match(cmp_match)
    );

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign wr_off = word_off(aw_addr);
    assign rd_off = word_off(s_axi_araddr);
    assign upper_high_byte = window_upper_limit[15:8];
    assign lower_high_byte = window_lower_limit[15:8];
    assign result_high_byte = conversion_value[15:8];

    assign window_match_flag = status[`AWHT_ST_MATCH_BIT];
    assign irq = |(status & mask);

    // read data and side-effect decode
    always @* begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b1;
        rd_clr_status = 1'b0;
        rd_clr_result = 1'b0;
        if (rd_off == `AWHT_OFF_CTRL) begin
            rd_mux[`AWHT_CTRL_EN_BIT] = ctrl_enable;
            rd_mux[`AWHT_CTRL_MODE_MSB:`AWHT_CTRL_MODE_LSB] = window_compare_mode_select;
            rd_mux[`AWHT_CTRL_ACC_MSB:`AWHT_CTRL_ACC_LSB] = accum_shift;
        end else if (rd_off == `AWHT_OFF_STATUS) begin
            rd_mux[1:0] = status;
            rd_clr_status = 1'b1;
        end else if (rd_off == `AWHT_OFF_MASK) begin
            rd_mux[1:0] = mask;
        end else if (rd_off == `AWHT_OFF_STAGE) begin
            rd_mux[7:0] = stage_byte;
        end else if (rd_off == `AWHT_OFF_RESULT) begin
            rd_mux[15:0] = conversion_value;
            rd_clr_result = 1'b1;
        end else if (rd_off == `AWHT_OFF_UPPER) begin
            rd_mux[15:0] = window_upper_limit;
        end else if (rd_off == `AWHT_OFF_LOWER) begin
            rd_mux[15:0] = window_lower_limit;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // write decode and flag clears
    always @* begin
        wr_ok = 1'b1;
        wr_clr = 2'h0;
        if (wr_off == `AWHT_OFF_CTRL || wr_off == `AWHT_OFF_MASK) begin
            wr_ok = 1'b1;
        end else if (wr_off == `AWHT_OFF_STATUS) begin
            // ones clear, zeros leave the flag alone
            if (wr_fire && w_strb[0]) begin
                wr_clr = w_data[1:0];
            end
        end else if (wr_off == `AWHT_OFF_STAGE || wr_off == `AWHT_OFF_UPPER) begin
            wr_ok = 1'b1;
        end else if (wr_off == `AWHT_OFF_LOWER || wr_off == `AWHT_OFF_RESULT) begin
            wr_ok = 1'b1;
        end else begin
            wr_ok = 1'b0;
        end
    end

    // sticky flags, a new event wins over any clear
    always @* begin
        flag_set = 2'h0;
        flag_set[`AWHT_ST_READY_BIT] = cmp_done;
        flag_set[`AWHT_ST_MATCH_BIT] = cmp_done & cmp_match;
        next_status = status;
        if (rd_take && (rd_clr_status || rd_clr_result)) begin
            next_status = 2'h0;
        end
        next_status = (next_status & ~wr_clr) | flag_set;
    end

    // write channel holding and response
    always @(posedge mclk) begin
        if (rst) begin
            aw_held <= 1'b0;
            aw_addr <= {ADDR_W{1'b0}};
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AWHT_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `AWHT_RESP_OKAY : `AWHT_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel
    always @(posedge mclk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `AWHT_RESP_OKAY;
        end else begin
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? `AWHT_RESP_OKAY : `AWHT_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // registers, staging byte, result and flags
    always @(posedge mclk) begin
        if (rst) begin
            ctrl_enable <= 1'b0;
            window_compare_mode_select <= `AWHT_RST_MODE;
            accum_shift <= `AWHT_RST_ACC;
            window_upper_limit <= `AWHT_RST_UPPER;
            window_lower_limit <= `AWHT_RST_LOWER;
            stage_byte <= `AWHT_RST_STAGE;
            conversion_value <= `AWHT_RST_RESULT;
            status <= `AWHT_RST_FLAGS;
            mask <= `AWHT_RST_FLAGS;
        end else begin
            status <= next_status;
            if (cmp_done) begin
                conversion_value <= cmp_total;
            end
            // a read of a pair parks its high byte for byte-wide readers
            if (rd_take && rd_off == `AWHT_OFF_RESULT) begin
                stage_byte <= result_high_byte;
            end else if (rd_take && rd_off == `AWHT_OFF_UPPER) begin
                stage_byte <= upper_high_byte;
            end else if (rd_take && rd_off == `AWHT_OFF_LOWER) begin
                stage_byte <= lower_high_byte;
            end
            if (wr_fire) begin
                if (wr_off == `AWHT_OFF_CTRL) begin
                    if (w_strb[0]) begin
                        ctrl_enable <= w_data[`AWHT_CTRL_EN_BIT];
                        window_compare_mode_select <=
                            w_data[`AWHT_CTRL_MODE_MSB:`AWHT_CTRL_MODE_LSB];
                    end
                    if (w_strb[1]) begin
                        accum_shift <= w_data[`AWHT_CTRL_ACC_MSB:`AWHT_CTRL_ACC_LSB];
                    end
                end else if (wr_off == `AWHT_OFF_MASK) begin
                    if (w_strb[0]) begin
                        mask <= w_data[1:0];
                    end
                end else if (wr_off == `AWHT_OFF_STAGE) begin
                    if (w_strb[0]) begin
                        stage_byte <= w_data[7:0];
                    end
                end else if (wr_off == `AWHT_OFF_UPPER) begin
                    // low byte alone only stages, high byte commits the pair
                    if (w_strb[1:0] == 2'h1) begin
                        stage_byte <= w_data[7:0];
                    end
                    window_upper_limit <= pair_write(window_upper_limit, stage_byte,
                        w_data[15:0], w_strb[1:0]);
                end else if (wr_off == `AWHT_OFF_LOWER) begin
                    if (w_strb[1:0] == 2'h1) begin
                        stage_byte <= w_data[7:0];
                    end
                    window_lower_limit <= pair_write(window_lower_limit, stage_byte,
                        w_data[15:0], w_strb[1:0]);
                end
            end
        end
    end

endmodule

// >>> tb/awht_props.sv
// bus handshake and window flag timing checks for the threshold block
// assumes awht_top ports, one clock, synchronous active-high reset
`timescale 1ns/1ns
`include "awht_defs.vh"
module awht_props #(
    parameter ADDR_W = 8
) (
    input wire mclk,
    input wire rst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire sample_valid,
    input wire window_match_flag
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence result_read_quiet;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `AWHT_OFF_RESULT && !sample_valid
            && !$past(sample_valid) && !$past(sample_valid, 2);
    endsequence
    write_answer_a: assert property (write_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two cycles after take");
    read_answer_a: assert property (read_taken |=> s_axi_rvalid)
        else $error("read data not one cycle after take");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels ready during response");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready during response");
    unmapped_read_a: assert property (read_taken ##0 s_axi_araddr == 8'h40 |=>
        s_axi_rresp == `AWHT_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    match_cause_a: assert property ($rose(window_match_flag) |-> $past(sample_valid, 2))
        else $error("match flag rose without finished sample");
    result_clear_a: assert property (result_read_quiet |-> ##2 !window_match_flag)
        else $error("result read left match flag set");
endmodule
bind awht_top awht_props #(.ADDR_W(ADDR_W)) i_awht_props (.*);

// >>> tb/test_awht_top.sv
// self-checking bench of the window threshold block over axi4-lite
// assumes awht_top with default parameters and the shared defines header
`timescale 1ns/1ns
`include "awht_defs.vh"
module test_awht_top;
    localparam [1:0] OK = `AWHT_RESP_OKAY;
    localparam [7:0] UP = `AWHT_OFF_UPPER;
    localparam [7:0] ST = `AWHT_OFF_STATUS;
    reg mclk, rst, awv, wv, bry, arv, rry, sv;
    reg [7:0] awa, ara;
    reg [31:0] wd;
    reg [3:0] ws;
    reg [9:0] smp;
    wire awr, wry, bv, arr, rv, flag, irq;
    wire [1:0] br, rr;
    wire [31:0] rd;
    integer errors, tests_run, i;
    awht_top i_awht_top (.mclk(mclk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wry), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .sample_valid(sv),
        .sample(smp), .window_match_flag(flag), .irq(irq));
    task test_done;
        begin
            $display("errors %0d tests_run %0d", errors, tests_run);
            if (errors == 0 && tests_run > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    task check(input [33:0] got, input [33:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wchk(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] e);
        reg done;
        begin
            @(posedge mclk);
            awa <= a;
            awv <= 1'b1;
            wd <= d;
            ws <= s;
            wv <= 1'b1;
            done = 1'b0;
            while (!done) begin
                @(posedge mclk);
                if (awv && awr) awv <= 1'b0;
                if (wv && wry) wv <= 1'b0;
                if (bv && bry) begin
                    done = 1'b1;
                    bry <= 1'b0;
                    check({32'h0, br}, {32'h0, e});
                end else if (bv) bry <= 1'b1;
            end
        end
    endtask
    task rchk(input [7:0] a, input [31:0] e, input [1:0] er);
        reg done;
        begin
            @(posedge mclk);
            ara <= a;
            arv <= 1'b1;
            done = 1'b0;
            while (!done) begin
                @(posedge mclk);
                if (arv && arr) arv <= 1'b0;
                if (rv && rry) begin
                    done = 1'b1;
                    rry <= 1'b0;
                    check({rr, rd}, {er, e});
                end else if (rv) rry <= 1'b1;
            end
        end
    endtask
    task send(input [9:0] v);
        begin
            @(posedge mclk);
            sv <= 1'b1;
            smp <= v;
            @(posedge mclk);
            sv <= 1'b0;
            repeat (3) @(posedge mclk);
        end
    endtask
    // irq and match flag after settling
    task pchk(input [1:0] e);
        begin
            repeat (2) @(posedge mclk);
            check({32'h0, irq, flag}, {32'h0, e});
        end
    endtask
    task mcase(input [2:0] m, input [9:0] v, input e);
        begin
            wchk(`AWHT_OFF_CTRL, {25'h0, m, 4'h1}, 4'h1, OK);
            send(v);
            pchk({1'b0, e});
            rchk(ST, {30'h0, e, 1'b1}, OK);
            pchk(2'b00);
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errors = errors + 1;
        test_done;
    end
    initial begin
        errors = 0;
        tests_run = 0;
        {rst, awv, wv, bry, arv, rry, sv} = 7'h40;
        {awa, ara, wd, ws, smp} = 0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rchk(UP, 32'h0, OK);
        rchk(8'h40, 32'h0, `AWHT_RESP_SLVERR);
        wchk(8'h40, 32'h5, 4'hf, `AWHT_RESP_SLVERR);
        wchk(UP, 32'habcd, 4'h3, OK);
        rchk(UP, 32'habcd, OK);
        rchk(`AWHT_OFF_STAGE, 32'hab, OK);
        wchk(UP, 32'h34, 4'h1, OK);
        rchk(`AWHT_OFF_STAGE, 32'h34, OK);
        wchk(UP, 32'h1200, 4'h2, OK);
        rchk(UP, 32'h1234, OK);
        wchk(UP, 32'h5, 4'h3, OK);
        wchk(`AWHT_OFF_LOWER, 32'h3, 4'h3, OK);
        mcase(`AWHT_MODE_ABOVE, 10'h5, 1'b0);
        mcase(`AWHT_MODE_ABOVE, 10'h6, 1'b1);
        mcase(`AWHT_MODE_BELOW, 10'h3, 1'b0);
        mcase(`AWHT_MODE_BELOW, 10'h2, 1'b1);
        mcase(`AWHT_MODE_INSIDE, 10'h3, 1'b1);
        mcase(`AWHT_MODE_INSIDE, 10'h5, 1'b1);
        mcase(`AWHT_MODE_INSIDE, 10'h6, 1'b0);
        mcase(`AWHT_MODE_OUTSIDE, 10'h6, 1'b1);
        mcase(`AWHT_MODE_OUTSIDE, 10'h2, 1'b1);
        mcase(`AWHT_MODE_OUTSIDE, 10'h4, 1'b0);
        mcase(`AWHT_MODE_NONE, 10'h3ff, 1'b0);
        mcase(3'h5, 10'h3ff, 1'b0);
        wchk(`AWHT_OFF_MASK, 32'h2, 4'h1, OK);
        wchk(`AWHT_OFF_CTRL, {25'h0, `AWHT_MODE_ABOVE, 4'h1}, 4'h1, OK);
        send(10'h6);
        pchk(2'b11);
        wchk(`AWHT_OFF_MASK, 32'h0, 4'h1, OK);
        pchk(2'b01);
        wchk(ST, 32'h0, 4'h1, OK);
        pchk(2'b01);
        wchk(`AWHT_OFF_MASK, 32'h2, 4'h1, OK);
        pchk(2'b11);
        wchk(ST, 32'h2, 4'h1, OK);
        pchk(2'b00);
        rchk(ST, 32'h1, OK);
        wchk(`AWHT_OFF_CTRL, {25'h0, `AWHT_MODE_ABOVE, 4'h0}, 4'h1, OK);
        send(10'h6);
        rchk(ST, 32'h0, OK);
        wchk(UP, 32'hffbf, 4'h3, OK);
        wchk(`AWHT_OFF_CTRL, 32'h621, 4'h3, OK);
        for (i = 0; i < 63; i = i + 1) send(10'h3ff);
        pchk(2'b00);
        send(10'h3ff);
        pchk(2'b11);
        rchk(`AWHT_OFF_RESULT, 32'hffc0, OK);
        pchk(2'b00);
        rchk(`AWHT_OFF_STAGE, 32'hff, OK);
        test_done;
    end
endmodule
